// File: src/program_control_pkg.sv
// Purpose: Shared constants for the program-controller register set
// Assumes: Register select codes are internal to the core
// Notes: Reset values of all control registers are zero
package program_control_pkg;
  localparam int ADDR_W = 24;
  localparam int PC_W = 21;
  localparam int PC_LO_W = 16;
  localparam int PC_HI_W = 5;
  localparam int PC_HI_LSB = 8;
  localparam int WORD_W = 16;
  localparam int FAST_STATUS_W = 13;
  localparam int CCR_W = 8;
  localparam int LOOP_STAT_W = 4;
  localparam int BYTE_W = 8;
  localparam int LONG_W = 32;
  localparam int ACC_W = 36;
  localparam int SEL_W = 4;
  localparam int FRAC_SHIFT = 1;

  // Register select codes
  localparam logic [SEL_W-1:0] SEL_PC = 4'h0;
  localparam logic [SEL_W-1:0] SEL_LOOP_END = 4'h1;
  localparam logic [SEL_W-1:0] SEL_OUTER_LOOP_END = 4'h2;
  localparam logic [SEL_W-1:0] SEL_STACK = 4'h3;
  localparam logic [SEL_W-1:0] SEL_FAST_RET = 4'h4;
  localparam logic [SEL_W-1:0] SEL_FAST_STATUS = 4'h5;
  localparam logic [SEL_W-1:0] SEL_MODE = 4'h6;
  localparam logic [SEL_W-1:0] SEL_STATUS = 4'h7;
  localparam logic [SEL_W-1:0] SEL_LOOP_CNT = 4'h8;
  localparam logic [SEL_W-1:0] SEL_OUTER_LOOP_CNT = 4'h9;

  localparam logic [1:0] STACK_DEPTH = 2'h2;
  localparam logic [1:0] STACK_ONE = 2'h1;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000001;
  localparam logic [WORD_W-1:0] LC_STEP = 16'h0001;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [FAST_STATUS_W-1:0] FAST_STATUS_RESET = 13'h0000;
  localparam logic [ACC_W-1:0] ACC_RESET = 36'h0_0000_0000;

  // Two's-complement word and long limits, unsigned word limit
  localparam logic [WORD_W-1:0] SWORD_MIN = 16'h8000;
  localparam logic [WORD_W-1:0] SWORD_MAX = 16'h7FFF;
  localparam logic [WORD_W-1:0] UWORD_MAX = 16'hFFFF;
  localparam logic [LONG_W-1:0] SLONG_MIN = 32'h8000_0000;
  localparam logic [LONG_W-1:0] SLONG_MAX = 32'h7FFF_FFFF;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG
  } operand_size_e;
endpackage

// File: src/program_control.sv
// Purpose: Program-controller registers and operand format unit
// Assumes: Core execution logic drives the event strobes
// Notes: All outputs registered; ce low freezes every flop
//
// What this block does
// - Program counter is a 16-bit register plus five status upper-byte bits.
// - 24-bit loop end register holds last word address of active loop.
// - Outer 24-bit loop end register keeps enclosing loop end address.
// - Hardware stack is a two-entry 24-bit LIFO behind one register.
// - Fast interrupt entry captures the 21-bit return address.
// - Fast interrupt entry captures condition codes, alignment, loop status.
// - 16-bit operating mode register configures core modes.
// - 16-bit status register holds flags, controls and PC upper bits.
// - 16-bit loop counter holds remaining iterations.
// - Outer 16-bit loop counter keeps enclosing loop count.
// - Integer 8/16/32-bit and fractional 16/32/36-bit operands supported.
// - Fraction binary point sits below the upper product word top bit.
// - Signed words span 8000..7FFF, signed longs from 8000_0000.
// - Unsigned values run from zero to all ones of their width.
// - Signed fractions are sign plus N-1 bits; long -1.0 is 80000000.
// - Word fraction is integer over 2^15, long over 2^31.
// - Accumulator needing extension bits overflows the upper word reading.
// - Instruction picks fractional multiply or integer long multiply.
`timescale 1ns/1ps
module program_control (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire logic [23:0] wr_data,
  input wire logic rd_en,
  input wire logic [3:0] rd_sel,
  output logic [23:0] rd_data,
  input wire logic pc_inc,
  input wire logic pc_load,
  input wire logic [20:0] pc_target,
  output logic [20:0] program_counter,
  output logic [15:0] operating_mode,
  input wire logic fast_entry,
  input wire logic align_state,
  input wire logic [3:0] loop_status,
  input wire logic loop_start,
  input wire logic [23:0] loop_end_in,
  input wire logic [15:0] loop_count_in,
  input wire logic loop_iter,
  input wire logic loop_exit,
  input wire logic [15:0] mul_a,
  input wire logic [15:0] mul_b,
  input wire logic mul_frac,
  output logic [35:0] product,
  input wire logic [35:0] acc_in,
  output logic [15:0] upper_word,
  output logic upper_ovf,
  input wire logic [31:0] ext_in,
  input wire logic [1:0] ext_size,
  input wire logic ext_signed,
  output logic [35:0] ext_out
);
  localparam int AW = program_control_pkg::ADDR_W;
  localparam int PW = program_control_pkg::PC_W;
  localparam int LW = program_control_pkg::PC_LO_W;
  localparam int HW = program_control_pkg::PC_HI_W;
  localparam int HL = program_control_pkg::PC_HI_LSB;
  localparam int WW = program_control_pkg::WORD_W;
  localparam int FW = program_control_pkg::FAST_STATUS_W;
  localparam int CW = program_control_pkg::CCR_W;
  localparam int BW = program_control_pkg::BYTE_W;
  localparam int GW = program_control_pkg::LONG_W;
  localparam int XW = program_control_pkg::ACC_W;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [LW-1:0] pc_low_reg, pc_low_next;
  logic [WW-1:0] status_reg, status_next;
  logic [WW-1:0] mode_reg, mode_next;
  logic [AW-1:0] loop_end_reg, loop_end_next;
  logic [AW-1:0] outer_end_reg, outer_end_next;
  logic [WW-1:0] loop_cnt_reg, loop_cnt_next;
  logic [WW-1:0] outer_cnt_reg, outer_cnt_next;
  logic [AW-1:0] stack0_reg, stack0_next;
  logic [AW-1:0] stack1_reg, stack1_next;
  logic [1:0] stack_cnt_reg, stack_cnt_next;
  logic [PW-1:0] fast_ret_reg, fast_ret_next;
  logic [FW-1:0] fast_stat_reg, fast_stat_next;
  logic [AW-1:0] rd_data_next;
  logic [PW-1:0] pc_full;
  logic [PW-1:0] pc_new;

  assign pc_full = {status_reg[HL +: HW], pc_low_reg};

  always_comb begin
    pc_low_next = pc_low_reg;
    status_next = status_reg;
    mode_next = mode_reg;
    loop_end_next = loop_end_reg;
    outer_end_next = outer_end_reg;
    loop_cnt_next = loop_cnt_reg;
    outer_cnt_next = outer_cnt_reg;
    stack0_next = stack0_reg;
    stack1_next = stack1_reg;
    stack_cnt_next = stack_cnt_reg;
    fast_ret_next = fast_ret_reg;
    fast_stat_next = fast_stat_reg;
    rd_data_next = rd_data;
    pc_new = pc_full;

    // Sequencing events from the execution unit
    if (pc_load) begin
      pc_new = pc_target;
    end else if (pc_inc) begin
      pc_new = pc_full + program_control_pkg::PC_STEP;
    end
    pc_low_next = pc_new[LW-1:0];
    status_next[HL +: HW] = pc_new[PW-1:LW];

    if (fast_entry) begin
      fast_ret_next = pc_full;
      fast_stat_next = {align_state, loop_status,
                        status_reg[CW-1:0]};
    end

    if (loop_start) begin
      outer_end_next = loop_end_reg;
      outer_cnt_next = loop_cnt_reg;
      loop_end_next = loop_end_in;
      loop_cnt_next = loop_count_in;
    end else if (loop_exit) begin
      loop_end_next = outer_end_reg;
      loop_cnt_next = outer_cnt_reg;
    end else if (loop_iter) begin
      loop_cnt_next = loop_cnt_reg - program_control_pkg::LC_STEP;
    end

    // Reads; a read of the stack port pops the top entry
    if (rd_en) begin
      case (rd_sel)
        program_control_pkg::SEL_PC:
          rd_data_next = {{(AW-PW){1'b0}}, pc_full};
        program_control_pkg::SEL_LOOP_END: rd_data_next = loop_end_reg;
        program_control_pkg::SEL_OUTER_LOOP_END:
          rd_data_next = outer_end_reg;
        program_control_pkg::SEL_STACK: begin
          rd_data_next = stack0_reg;
          if (stack_cnt_reg != 2'h0) begin
            stack0_next = stack1_reg;
            stack_cnt_next = stack_cnt_reg - program_control_pkg::STACK_ONE;
          end
        end
        program_control_pkg::SEL_FAST_RET:
          rd_data_next = {{(AW-PW){1'b0}}, fast_ret_reg};
        program_control_pkg::SEL_FAST_STATUS:
          rd_data_next = {{(AW-FW){1'b0}}, fast_stat_reg};
        program_control_pkg::SEL_MODE:
          rd_data_next = {{(AW-WW){1'b0}}, mode_reg};
        program_control_pkg::SEL_STATUS:
          rd_data_next = {{(AW-WW){1'b0}}, status_reg};
        program_control_pkg::SEL_LOOP_CNT:
          rd_data_next = {{(AW-WW){1'b0}}, loop_cnt_reg};
        program_control_pkg::SEL_OUTER_LOOP_CNT:
          rd_data_next = {{(AW-WW){1'b0}}, outer_cnt_reg};
        default: rd_data_next = program_control_pkg::ADDR_RESET;
      endcase
    end

    // Writes take priority over same-cycle events on their target
    if (wr_en) begin
      case (wr_sel)
        program_control_pkg::SEL_PC: begin
          pc_low_next = wr_data[LW-1:0];
          status_next[HL +: HW] = wr_data[PW-1:LW];
        end
        program_control_pkg::SEL_LOOP_END: loop_end_next = wr_data;
        program_control_pkg::SEL_OUTER_LOOP_END: outer_end_next = wr_data;
        program_control_pkg::SEL_STACK: begin
          stack1_next = stack0_next;
          stack0_next = wr_data;
          if (stack_cnt_next != program_control_pkg::STACK_DEPTH) begin
            stack_cnt_next = stack_cnt_next + program_control_pkg::STACK_ONE;
          end
        end
        program_control_pkg::SEL_FAST_RET:
          fast_ret_next = wr_data[PW-1:0];
        program_control_pkg::SEL_FAST_STATUS:
          fast_stat_next = wr_data[FW-1:0];
        program_control_pkg::SEL_MODE: mode_next = wr_data[WW-1:0];
        program_control_pkg::SEL_STATUS:
          status_next = wr_data[WW-1:0];
        program_control_pkg::SEL_LOOP_CNT: loop_cnt_next = wr_data[WW-1:0];
        program_control_pkg::SEL_OUTER_LOOP_CNT:
          outer_cnt_next = wr_data[WW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_low_reg <= program_control_pkg::WORD_RESET;
      status_reg <= program_control_pkg::WORD_RESET;
      mode_reg <= program_control_pkg::WORD_RESET;
      loop_end_reg <= program_control_pkg::ADDR_RESET;
      outer_end_reg <= program_control_pkg::ADDR_RESET;
      loop_cnt_reg <= program_control_pkg::WORD_RESET;
      outer_cnt_reg <= program_control_pkg::WORD_RESET;
      stack0_reg <= program_control_pkg::ADDR_RESET;
      stack1_reg <= program_control_pkg::ADDR_RESET;
      stack_cnt_reg <= 2'h0;
      fast_ret_reg <= {PW{1'b0}};
      fast_stat_reg <= program_control_pkg::FAST_STATUS_RESET;
      rd_data <= program_control_pkg::ADDR_RESET;
      program_counter <= {PW{1'b0}};
      operating_mode <= program_control_pkg::WORD_RESET;
    end else if (ce) begin
      pc_low_reg <= pc_low_next;
      status_reg <= status_next;
      mode_reg <= mode_next;
      loop_end_reg <= loop_end_next;
      outer_end_reg <= outer_end_next;
      loop_cnt_reg <= loop_cnt_next;
      outer_cnt_reg <= outer_cnt_next;
      stack0_reg <= stack0_next;
      stack1_reg <= stack1_next;
      stack_cnt_reg <= stack_cnt_next;
      fast_ret_reg <= fast_ret_next;
      fast_stat_reg <= fast_stat_next;
      rd_data <= rd_data_next;
      program_counter <= {status_next[HL +: HW], pc_low_next};
      operating_mode <= mode_next;
    end
  end

  // ----------------------------------------------------------------
  // Operand format unit
  // ----------------------------------------------------------------
  logic signed [GW-1:0] mul_raw;
  logic [XW-1:0] mul_ext;
  logic [XW-1:0] product_next;
  logic [XW-GW:0] acc_top;
  logic ovf_next;
  logic [WW-1:0] upper_next;
  logic [XW-1:0] ext_next;
  logic fill;

  assign mul_raw = $signed(mul_a) * $signed(mul_b);
  assign mul_ext = {{(XW-GW){mul_raw[GW-1]}}, mul_raw};
  assign acc_top = acc_in[XW-1:GW-1];

  always_comb begin
    // Fraction: shift aligns binary point below the upper word MSB
    if (mul_frac) begin
      product_next = mul_ext << program_control_pkg::FRAC_SHIFT;
    end else begin
      product_next = mul_ext;
    end

    // Upper word integer reading saturates when extension is in use
    ovf_next = !((&acc_top) || !(|acc_top));
    if (ovf_next) begin
      upper_next = acc_in[XW-1] ? program_control_pkg::SWORD_MIN
                                : program_control_pkg::SWORD_MAX;
    end else begin
      upper_next = acc_in[GW-1:GW-WW];
    end

    // Sign or zero extension to accumulator width
    fill = 1'b0;
    ext_next = program_control_pkg::ACC_RESET;
    case (program_control_pkg::operand_size_e'(ext_size))
      program_control_pkg::SIZE_BYTE: begin
        fill = ext_signed & ext_in[BW-1];
        ext_next = {{(XW-BW){fill}}, ext_in[BW-1:0]};
      end
      program_control_pkg::SIZE_WORD: begin
        fill = ext_signed & ext_in[WW-1];
        ext_next = {{(XW-WW){fill}}, ext_in[WW-1:0]};
      end
      program_control_pkg::SIZE_LONG: begin
        fill = ext_signed & ext_in[GW-1];
        ext_next = {{(XW-GW){fill}}, ext_in};
      end
      default: begin
        fill = 1'b0;
        ext_next = program_control_pkg::ACC_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      product <= program_control_pkg::ACC_RESET;
      upper_word <= program_control_pkg::WORD_RESET;
      upper_ovf <= 1'b0;
      ext_out <= program_control_pkg::ACC_RESET;
    end else if (ce) begin
      product <= product_next;
      upper_word <= upper_next;
      upper_ovf <= ovf_next;
      ext_out <= ext_next;
    end
  end
endmodule

// File: testbench/program_control_sva.sv
// Purpose: Port assertions for the program controller
// Assumes: Bound to every program_control instance
// Notes: Registered outputs are checked one edge after their inputs
`timescale 1ns/1ps
module program_control_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic pc_inc,
  input wire logic pc_load,
  input wire logic [20:0] pc_target,
  input wire logic [20:0] program_counter,
  input wire logic [15:0] mul_a,
  input wire logic [15:0] mul_b,
  input wire logic mul_frac,
  input wire logic [35:0] product,
  input wire logic [35:0] acc_in,
  input wire logic [15:0] upper_word,
  input wire logic upper_ovf,
  input wire logic [31:0] ext_in,
  input wire logic [1:0] ext_size,
  input wire logic ext_signed,
  input wire logic [35:0] ext_out
);
  logic signed [35:0] a36, b36, ip, fp;
  logic ovf;
  logic [15:0] uw;
  logic [35:0] ex;
  assign a36 = {{20{mul_a[15]}}, mul_a};
  assign b36 = {{20{mul_b[15]}}, mul_b};
  assign ip = a36 * b36;
  assign fp = ip <<< 1;
  assign ovf = !((&acc_in[35:31]) || !(|acc_in[35:31]));
  assign uw = !ovf ? acc_in[31:16] : (acc_in[35] ? 16'h8000 : 16'h7FFF);
  always_comb begin
    case (ext_size)
      2'h0: ex = {{28{ext_signed & ext_in[7]}}, ext_in[7:0]};
      2'h1: ex = {{20{ext_signed & ext_in[15]}}, ext_in[15:0]};
      2'h2: ex = {{4{ext_signed & ext_in[31]}}, ext_in};
      default: ex = 36'h0;
    endcase
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  pc_load_a: assert property (ce && pc_load && !wr_en |=>
    program_counter == $past(pc_target)) else $error("pc load wrong");
  pc_step_a: assert property (ce && pc_inc && !pc_load && !wr_en |=>
    program_counter == $past(program_counter) + 21'h1)
    else $error("pc step wrong");
  freeze_hold_a: assert property (!ce |=> $stable(program_counter) &&
    $stable(product) && $stable(ext_out)) else $error("freeze broken");
  frac_mul_a: assert property (ce && mul_frac |=>
    product == $past(fp)) else $error("fractional product wrong");
  int_mul_a: assert property (ce && !mul_frac |=>
    product == $past(ip)) else $error("integer product wrong");
  upper_ovf_a: assert property (ce |=>
    upper_ovf == $past(ovf)) else $error("overflow flag wrong");
  upper_word_a: assert property (ce |=>
    upper_word == $past(uw)) else $error("upper word wrong");
  operand_ext_a: assert property (ce |=>
    ext_out == $past(ex)) else $error("extension wrong");
endmodule
bind program_control program_control_sva u_sva (
  .clk(clk), .rst_b(rst_b), .ce(ce), .wr_en(wr_en), .pc_inc(pc_inc),
  .pc_load(pc_load), .pc_target(pc_target),
  .program_counter(program_counter), .mul_a(mul_a), .mul_b(mul_b),
  .mul_frac(mul_frac), .product(product), .acc_in(acc_in),
  .upper_word(upper_word), .upper_ovf(upper_ovf), .ext_in(ext_in),
  .ext_size(ext_size), .ext_signed(ext_signed), .ext_out(ext_out)
);

// File: testbench/core_sequencer.sv
// Purpose: Stand-in for the core sequencer driving program events
// Assumes: Strobes follow the requests one cycle later
// Notes: Interrupt entry also advances the counter, as in real flow
`timescale 1ns/1ps
module core_sequencer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic irq,
  output logic pc_inc,
  output logic fast_entry
);
  logic inc_next, entry_next;
  always_comb begin
    inc_next = run | irq;
    entry_next = irq;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_inc <= 1'h0;
      fast_entry <= 1'h0;
    end else begin
      pc_inc <= inc_next;
      fast_entry <= entry_next;
    end
  end
endmodule

// File: testbench/program_control_tb.sv
// Purpose: Self-checking bench for the program controller
// Assumes: One 40 MHz clock, active-low asynchronous reset
// Notes: Each scenario drives and judges on its own
`timescale 1ns/1ps
module program_control_tb;
  logic clk, rst_b, ce, wr_en, rd_en, pc_load, run, irq, align_state;
  logic loop_start, loop_iter, loop_exit, mul_frac, ext_signed;
  logic pc_inc, fast_entry, upper_ovf;
  logic [3:0] wr_sel, rd_sel, loop_status;
  logic [23:0] wr_data, rd_data, loop_end_in;
  logic [20:0] pc_target, program_counter;
  logic [15:0] operating_mode, loop_count_in, mul_a, mul_b, upper_word;
  logic [35:0] product, acc_in, ext_out, v;
  logic [31:0] ext_in;
  logic [1:0] ext_size;
  int n_mismatch, total_checks;
  program_control u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .rd_en(rd_en), .rd_sel(rd_sel),
    .rd_data(rd_data), .pc_inc(pc_inc), .pc_load(pc_load),
    .pc_target(pc_target), .program_counter(program_counter),
    .operating_mode(operating_mode), .fast_entry(fast_entry),
    .align_state(align_state), .loop_status(loop_status),
    .loop_start(loop_start), .loop_end_in(loop_end_in),
    .loop_count_in(loop_count_in), .loop_iter(loop_iter),
    .loop_exit(loop_exit), .mul_a(mul_a), .mul_b(mul_b),
    .mul_frac(mul_frac), .product(product), .acc_in(acc_in),
    .upper_word(upper_word), .upper_ovf(upper_ovf), .ext_in(ext_in),
    .ext_size(ext_size), .ext_signed(ext_signed), .ext_out(ext_out));
  core_sequencer u_seq (.clk(clk), .rst_b(rst_b), .run(run), .irq(irq),
    .pc_inc(pc_inc), .fast_entry(fast_entry));
  // ----------------------------------------
  // Bus tasks and scenarios
  // ----------------------------------------
  task automatic chk(input string n, input logic [35:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [23:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] s);
    @(posedge clk);
    rd_en <= 1'h1;
    rd_sel <= s;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 v = {12'h0, rd_data};
  endtask
  task automatic t_regs();
    int w [11] = '{21, 24, 24, 24, 21, 13, 16, 16, 16, 16, 0};
    for (int s = 0; s < 11; s++) begin
      rd(4'(s));
      chk("reset value", 36'h0, v);
    end
    for (int s = 0; s < 11; s++) begin
      wr(4'(s), 24'hFFFFFF);
      rd(4'(s));
      chk("register width", (36'h1 << w[s]) - 36'h1, v);
    end
    chk("mode output", 36'hFFFF, {20'h0, operating_mode});
  endtask
  task automatic t_stack();
    wr(4'h3, 24'hA1A1A1);
    wr(4'h3, 24'hB2B2B2);
    wr(4'h3, 24'hC3C3C3);
    rd(4'h3);
    chk("stack top", 36'hC3C3C3, v);
    rd(4'h3);
    chk("stack second", 36'hB2B2B2, v);
  endtask
  task automatic t_pc();
    wr(4'h7, 24'h000000);
    @(posedge clk);
    pc_load <= 1'h1;
    pc_target <= 21'h1FFFFE;
    @(posedge clk);
    pc_load <= 1'h0;
    rd(4'h7);
    chk("status pc bits", 36'h1F, {31'h0, v[12:8]});
    @(posedge clk);
    run <= 1'h1;
    repeat (3) @(posedge clk);
    run <= 1'h0;
    @(posedge clk);
    ce <= 1'h0;
    pc_load <= 1'h1;
    repeat (3) @(posedge clk);
    ce <= 1'h1;
    pc_load <= 1'h0;
    @(posedge clk);
    #1 chk("pc wrap", 36'h1, {15'h0, program_counter});
  endtask
  task automatic t_fast();
    wr(4'h7, 24'h0000A5);
    wr(4'h0, 24'h012345);
    @(posedge clk);
    irq <= 1'h1;
    align_state <= 1'h1;
    loop_status <= 4'h6;
    @(posedge clk);
    irq <= 1'h0;
    rd(4'h4);
    chk("fast return", 36'h012345, v);
    rd(4'h5);
    chk("fast status", 36'h16A5, v);
    chk("pc after entry", 36'h012346, {15'h0, program_counter});
  endtask
  task automatic t_loop();
    @(posedge clk);
    loop_start <= 1'h1;
    loop_end_in <= 24'h001000;
    loop_count_in <= 16'h0005;
    @(posedge clk);
    loop_end_in <= 24'h002000;
    loop_count_in <= 16'h0003;
    @(posedge clk);
    loop_start <= 1'h0;
    loop_iter <= 1'h1;
    @(posedge clk);
    loop_iter <= 1'h0;
    rd(4'h8);
    chk("loop count", 36'h2, v);
    rd(4'h2);
    chk("outer end", 36'h001000, v);
    rd(4'h9);
    chk("outer count", 36'h5, v);
    @(posedge clk);
    loop_exit <= 1'h1;
    @(posedge clk);
    loop_exit <= 1'h0;
    rd(4'h1);
    chk("restored end", 36'h001000, v);
    rd(4'h8);
    chk("restored count", 36'h5, v);
  endtask
  task automatic fm(input logic [15:0] a, input logic f,
      input logic [35:0] ac, input logic [31:0] x, input logic [1:0] sz,
      input logic sg, input logic [35:0] ep, eu, ee);
    @(posedge clk);
    mul_a <= a;
    mul_b <= a;
    mul_frac <= f;
    acc_in <= ac;
    ext_in <= x;
    ext_size <= sz;
    ext_signed <= sg;
    @(posedge clk);
    #1 chk("product", ep, product);
    chk("upper word", eu, {19'h0, upper_ovf, upper_word});
    chk("extension", ee, ext_out);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rst_b, wr_en, rd_en, pc_load, run, irq, align_state} = '0;
    {loop_start, loop_iter, loop_exit, mul_frac, ext_signed} = '0;
    {wr_sel, rd_sel, loop_status, wr_data, loop_end_in} = '0;
    {pc_target, loop_count_in, mul_a, mul_b, acc_in, ext_in} = '0;
    ext_size = 2'h0;
    ce = 1'h1;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    t_regs();
    t_stack();
    t_pc();
    t_fast();
    t_loop();
    fm(16'h8000, 1'h1, 36'h080000000, 32'h80, 2'h0, 1'h1,
      36'h080000000, 36'h17FFF, 36'hFFFFFFF80);
    fm(16'h8000, 1'h0, 36'hF80000000, 32'hFFFF, 2'h1, 1'h0,
      36'h040000000, 36'h08000, 36'h00000FFFF);
    fm(16'h7FFF, 1'h1, 36'h040000000, 32'h80000000, 2'h2, 1'h1,
      36'h07FFE0002, 36'h04000, 36'hF80000000);
    fm(16'hFFFF, 1'h0, 36'hE00000000, 32'hFFFFFFFF, 2'h3, 1'h1,
      36'h1, 36'h18000, 36'h0);
    stop_test();
  end
endmodule
